// ---- core/ssw_top.sv ----
/*
 Supply supervisor with watchdog: reset sequencer, undervoltage filter,
 timing-pin configuration latch, watchdog state machine and register port.
 Assumes comparator outcomes and pin senses arrive asynchronously, and a
 register master on the same clock that never issues both strobes at once.
*/
// Added by the designer: the plain strobed port and the address map.
//
// Contract
// - Reset stays asserted while the supply is above power-on level but below minimum operating level.
// - The fault output floats whenever reset is asserted, whatever the kick input does.
// - Above minimum operating level, reset follows the threshold comparison outcome and the manual reset input.
// - An open or pulled-up timing pin selects a factory timeout, a capacitor selects capacitor timing.
// - Factory timeouts are 1600 ms nominal (1360 to 1840) open and 200 ms (170 to 230) pulled up.
// - With the enable pin low the watchdog is disabled in every timing-pin configuration.
// - Standard capacitor timing gives 3.23 ms per nanofarad plus 0.381 ms.
// - Extended capacitor timing gives 77.4 ms per nanofarad plus 55 ms.
// - Capacitor timing places the minimum at 0.905 and the maximum at 1.095 of nominal.
// - Nanosecond dips do not reset, and a deeper dip resets sooner.
// - A falling supply trips at the lower threshold, a rising one at lower threshold plus hysteresis.
// - Only a falling kick edge counts, and the controller kicks before the minimum timeout.
// - While reset is asserted the watchdog is off and kicks are ignored, resuming after release.
// - After the enable pin goes from low to high, kicks are ignored for 150 us.
`include "ssw_map.svh"

module ssw_top #(
	parameter int FLOAT_TIMEOUT_MS = 1600,
	parameter int PULL_TIMEOUT_MS  = 200,
	parameter int RST_DELAY_MS     = 200
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        supplyAboveMin,
	input  wire logic        supplyAboveLower,
	input  wire logic        supplyAboveUpper,
	input  wire logic        supplyDeepBelow,
	input  wire logic        manualResetInN,
	input  wire logic        watchdogKickIn,
	input  wire logic        watchdogEnablePin,
	input  wire logic        timingPinOpen,
	input  wire logic        timingPinPulled,
	input  wire logic        extendedScaling,
	output logic             resetOutN,
	output logic             resetOutOe,
	output logic             watchdogFaultOut,
	output logic             watchdogFaultOe,
	output logic             irq,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrStb,
	input  wire logic        regRdStb,
	output logic [31:0]      regRdData
);
	localparam int P_MIN   = 0;
	localparam int P_LOW   = 1;
	localparam int P_UP    = 2;
	localparam int P_DEEP  = 3;
	localparam int P_MR    = 4;
	localparam int P_KICK  = 5;
	localparam int P_EN    = 6;
	localparam int P_OPEN  = 7;
	localparam int P_PULL  = 8;
	localparam int P_EXT   = 9;

	localparam logic [31:0] FLOAT_CYC = 32'(FLOAT_TIMEOUT_MS * `SSW_CYC_PER_MS);
	localparam logic [31:0] PULL_CYC  = 32'(PULL_TIMEOUT_MS * `SSW_CYC_PER_MS);
	localparam logic [31:0] RSTD_CYC  = 32'(RST_DELAY_MS * `SSW_CYC_PER_MS);
	localparam logic [31:0] SETUP_CYC = 32'(`SSW_SETUP_CYC);
	localparam logic [7:0]  UV_SHALLOW = 8'(`SSW_UV_SHALLOW_CYC);
	localparam logic [7:0]  UV_DEEP    = 8'(`SSW_UV_DEEP_CYC);

	ssw_pkg::ssw_top_s s;
	ssw_pkg::ssw_top_s next_s;

	ssw_tmr_if rstTif ();
	ssw_tmr_if wdTif ();

	logic [9:0]  pinVec;
	logic        aboveMin;
	logic        aboveLower;
	logic        aboveUpper;
	logic        deepBelow;
	logic        mrN;
	logic        kickLvl;
	logic        enLvl;
	logic        uvTrip;
	logic        dropReq;
	logic        resetAsserted;
	logic        kickFall;
	logic        evRst;
	logic        evWdf;
	logic        evCfg;
	logic [31:0] capUs;
	logic [31:0] nomCyc;
	logic [31:0] minCyc;
	logic [31:0] maxCyc;
	logic [47:0] prodMin;
	logic [47:0] prodMax;
	logic [9:0]  minPermil;
	logic [10:0] maxPermil;

	ssw_timer u_rst_timer (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.tif (rstTif)
	);

	ssw_timer u_wd_timer (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.tif (wdTif)
	);

	assign pinVec = {extendedScaling, timingPinPulled, timingPinOpen, watchdogEnablePin,
		watchdogKickIn, manualResetInN, supplyDeepBelow, supplyAboveUpper,
		supplyAboveLower, supplyAboveMin};

	// Synchronised pin levels
	assign aboveMin   = s.sync2[P_MIN];
	assign aboveLower = s.sync2[P_LOW];
	assign aboveUpper = s.sync2[P_UP];
	assign deepBelow  = s.sync2[P_DEEP];
	assign mrN        = s.sync2[P_MR];
	assign kickLvl    = s.sync2[P_KICK];
	assign enLvl      = s.sync2[P_EN];

	// Undervoltage must persist; a deep dip needs a shorter persistence
	assign uvTrip = !aboveLower && (s.uvCnt >= (deepBelow ? UV_DEEP : UV_SHALLOW));
	assign dropReq = !aboveMin || uvTrip || !mrN;
	assign resetAsserted = (s.rs != ssw_pkg::RS_RUN);
	assign kickFall = s.kickPrev && !kickLvl;

	// Timeout from the latched configuration
	always_comb begin
		if (s.ext) begin
			capUs = 32'(s.capLatched) * 32'(`SSW_EXT_SLOPE_US) + 32'(`SSW_EXT_OFS_US);
		end else begin
			capUs = 32'(s.capLatched) * 32'(`SSW_STD_SLOPE_US) + 32'(`SSW_STD_OFS_US);
		end
		case (s.cfg)
			ssw_pkg::CFG_FLOAT: begin
				nomCyc = FLOAT_CYC;
			end
			ssw_pkg::CFG_PULLED: begin
				nomCyc = PULL_CYC;
			end
			default: begin
				nomCyc = capUs * 32'(`SSW_CYC_PER_US);
			end
		endcase
		if (s.cfg == ssw_pkg::CFG_CAP) begin
			minPermil = 10'(`SSW_CAP_MIN_PERMIL);
			maxPermil = 11'(`SSW_CAP_MAX_PERMIL);
		end else begin
			minPermil = 10'(`SSW_FAC_MIN_PERMIL);
			maxPermil = 11'(`SSW_FAC_MAX_PERMIL);
		end
		prodMin = 48'(nomCyc) * 48'(minPermil);
		prodMax = 48'(nomCyc) * 48'(maxPermil);
		minCyc = 32'(prodMin / 48'd1000);
		maxCyc = 32'(prodMax / 48'd1000);
	end

	always_comb begin
		next_s = s;
		next_s.sync1 = pinVec;
		next_s.sync2 = s.sync1;
		next_s.kickPrev = kickLvl;
		next_s.enPrev = enLvl;
		rstTif.load = 1'b0;
		rstTif.run = 1'b0;
		rstTif.loadVal = RSTD_CYC;
		wdTif.load = 1'b0;
		wdTif.run = 1'b0;
		wdTif.loadVal = nomCyc;
		evRst = 1'b0;
		evWdf = 1'b0;
		evCfg = 1'b0;

		// Persistence counter of the lower comparison
		if (aboveLower) begin
			next_s.uvCnt = 8'h00;
		end else if (!uvTrip) begin
			next_s.uvCnt = s.uvCnt + 8'h01;
		end

		// Reset sequencer
		case (s.rs)
			ssw_pkg::RS_LOW: begin
				if (aboveMin && aboveUpper && mrN) begin
					next_s.rs = ssw_pkg::RS_DELAY;
					rstTif.load = 1'b1;
					if (s.sync2[P_OPEN]) begin
						next_s.cfg = ssw_pkg::CFG_FLOAT;
					end else if (s.sync2[P_PULL]) begin
						next_s.cfg = ssw_pkg::CFG_PULLED;
					end else begin
						next_s.cfg = ssw_pkg::CFG_CAP;
					end
					next_s.ext = s.sync2[P_EXT];
					next_s.capLatched = s.ctrlCap;
					evCfg = 1'b1;
				end
			end
			ssw_pkg::RS_DELAY: begin
				rstTif.run = 1'b1;
				if (dropReq) begin
					next_s.rs = ssw_pkg::RS_LOW;
				end else if (rstTif.expired) begin
					next_s.rs = ssw_pkg::RS_RUN;
				end
			end
			ssw_pkg::RS_RUN: begin
				if (dropReq) begin
					next_s.rs = ssw_pkg::RS_LOW;
					evRst = 1'b1;
				end
			end
			default: begin
				next_s.rs = ssw_pkg::RS_LOW;
			end
		endcase

		// Watchdog
		case (s.wd)
			ssw_pkg::WD_OFF: begin
				if (!resetAsserted && enLvl) begin
					wdTif.load = 1'b1;
					if (s.enPrev) begin
						next_s.wd = ssw_pkg::WD_RUN;
					end else begin
						next_s.wd = ssw_pkg::WD_SETUP;
						wdTif.loadVal = SETUP_CYC;
					end
				end
			end
			ssw_pkg::WD_SETUP: begin
				wdTif.run = 1'b1;
				if (wdTif.expired) begin
					next_s.wd = ssw_pkg::WD_RUN;
					wdTif.load = 1'b1;
				end
			end
			ssw_pkg::WD_RUN: begin
				wdTif.run = 1'b1;
				if (kickFall) begin
					wdTif.load = 1'b1;
				end else if (wdTif.expired) begin
					next_s.wd = ssw_pkg::WD_FAULT;
					wdTif.load = 1'b1;
					wdTif.loadVal = RSTD_CYC;
					evWdf = 1'b1;
				end
			end
			ssw_pkg::WD_FAULT: begin
				wdTif.run = 1'b1;
				if (wdTif.expired) begin
					next_s.wd = ssw_pkg::WD_RUN;
					wdTif.load = 1'b1;
				end
			end
			default: begin
				next_s.wd = ssw_pkg::WD_OFF;
			end
		endcase
		if (resetAsserted || !enLvl) begin
			next_s.wd = ssw_pkg::WD_OFF;
		end

		// Register writes
		if (regWrStb && (regAddr == `SSW_REG_CTRL)) begin
			next_s.ctrlCap = regWrData[13:0];
		end
		if (regWrStb && (regAddr == `SSW_REG_MASK)) begin
			next_s.mask = regWrData[2:0];
		end

		// Sticky events: read clears, a new event wins over the clear
		if (regRdStb && (regAddr == `SSW_REG_STATUS)) begin
			next_s.status = 3'h0;
		end
		next_s.status[`SSW_EV_RST] = next_s.status[`SSW_EV_RST] | evRst;
		next_s.status[`SSW_EV_WDF] = next_s.status[`SSW_EV_WDF] | evWdf;
		next_s.status[`SSW_EV_CFG] = next_s.status[`SSW_EV_CFG] | evCfg;

		// Read data stand one cycle after the strobe
		next_s.rdata = 32'h0;
		if (regRdStb) begin
			case (regAddr)
				`SSW_REG_CTRL: begin
					next_s.rdata = 32'(s.ctrlCap);
				end
				`SSW_REG_STATUS: begin
					next_s.rdata = 32'(s.status);
				end
				`SSW_REG_MASK: begin
					next_s.rdata = 32'(s.mask);
				end
				`SSW_REG_STATE: begin
					next_s.rdata = 32'({s.wd, s.rs, s.cfg, s.ext, resetAsserted, watchdogFaultOe});
				end
				`SSW_REG_TNOM: begin
					next_s.rdata = nomCyc;
				end
				`SSW_REG_TMIN: begin
					next_s.rdata = minCyc;
				end
				`SSW_REG_TMAX: begin
					next_s.rdata = maxCyc;
				end
				default: begin
					next_s.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.rs <= ssw_pkg::RS_LOW;
			s.wd <= ssw_pkg::WD_OFF;
			s.cfg <= ssw_pkg::CFG_FLOAT;
			s.ctrlCap <= `SSW_CTRL_RST;
			s.mask <= `SSW_MASK_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Open-drain pins: only ever pull low
	assign resetOutN = 1'b0;
	assign resetOutOe = resetAsserted;
	assign watchdogFaultOut = 1'b0;
	assign watchdogFaultOe = (s.wd == ssw_pkg::WD_FAULT) && !resetAsserted;
	assign irq = |(s.status & s.mask);
	assign regRdData = s.rdata;
endmodule

// ---- core/ssw_map.svh ----
/*
 Offsets, field positions, reset values and timing counts of the supervisor.
 Assumes a 10 MHz system clock; all counts derive from SSW_CLK_HZ.
*/
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH

// Clock rate and derived cycle units
`define SSW_CLK_HZ 10000000
`define SSW_CYC_PER_US (`SSW_CLK_HZ / 1000000)
`define SSW_CYC_PER_MS (`SSW_CLK_HZ / 1000)

// Kick blanking after the watchdog is enabled, least time
`define SSW_SETUP_US 150
`define SSW_SETUP_CYC ((`SSW_SETUP_US * `SSW_CLK_HZ + 999999) / 1000000)

// Undervoltage persistence before reset, shallow and deep dips, least times
`define SSW_UV_SHALLOW_US 6
`define SSW_UV_DEEP_US 1
`define SSW_UV_SHALLOW_CYC ((`SSW_UV_SHALLOW_US * `SSW_CLK_HZ + 999999) / 1000000)
`define SSW_UV_DEEP_CYC ((`SSW_UV_DEEP_US * `SSW_CLK_HZ + 999999) / 1000000)

// Capacitor timing, capacitance counted in 100 pF steps
`define SSW_STD_SLOPE_US 323
`define SSW_STD_OFS_US 381
`define SSW_EXT_SLOPE_US 7740
`define SSW_EXT_OFS_US 55000

// Timeout spread in thousandths of nominal
`define SSW_CAP_MIN_PERMIL 905
`define SSW_CAP_MAX_PERMIL 1095
`define SSW_FAC_MIN_PERMIL 850
`define SSW_FAC_MAX_PERMIL 1150

// Register byte addresses
`define SSW_REG_CTRL 8'h00
`define SSW_REG_STATUS 8'h04
`define SSW_REG_MASK 8'h08
`define SSW_REG_STATE 8'h0c
`define SSW_REG_TNOM 8'h10
`define SSW_REG_TMIN 8'h14
`define SSW_REG_TMAX 8'h18

// Status and mask bit positions
`define SSW_EV_RST 0
`define SSW_EV_WDF 1
`define SSW_EV_CFG 2

// Reset values
`define SSW_CTRL_RST 14'h000a
`define SSW_MASK_RST 3'h0

`endif

// ---- core/ssw_pkg.sv ----
/*
 Types of the supervisor: state encodings and packed state records.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ssw_pkg;

	typedef enum logic [3:0] {
		WD_OFF   = 4'h1,
		WD_SETUP = 4'h2,
		WD_RUN   = 4'h4,
		WD_FAULT = 4'h8
	} ssw_wd_e;

	typedef enum logic [2:0] {
		RS_LOW   = 3'h1,
		RS_DELAY = 3'h2,
		RS_RUN   = 3'h4
	} ssw_rs_e;

	typedef enum logic [1:0] {
		CFG_FLOAT  = 2'h0,
		CFG_PULLED = 2'h1,
		CFG_CAP    = 2'h2
	} ssw_cfg_e;

	typedef struct packed {
		logic [31:0] cnt;
	} ssw_tmr_s;

	typedef struct packed {
		logic [9:0]  sync1;
		logic [9:0]  sync2;
		logic        kickPrev;
		logic        enPrev;
		ssw_rs_e     rs;
		ssw_wd_e     wd;
		logic [7:0]  uvCnt;
		ssw_cfg_e    cfg;
		logic        ext;
		logic [13:0] capLatched;
		logic [13:0] ctrlCap;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic [31:0] rdata;
	} ssw_top_s;

endpackage

// ---- core/ssw_tmr_if.sv ----
/*
 Control bundle between the supervisor and one of its down-counters.
 Assumes both ends share the supervisor clock.
*/
interface ssw_tmr_if;
	logic        load;
	logic        run;
	logic [31:0] loadVal;
	logic        expired;

	modport ctl (output load, output run, output loadVal, input expired);
	modport tmr (input load, input run, input loadVal, output expired);
endinterface

// ---- core/ssw_timer.sv ----
/*
 Loadable down-counter used for watchdog and reset-delay timing.
 Assumes the controller holds run high while the count must advance.
*/
module ssw_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	ssw_tmr_if.tmr   tif
);
	ssw_pkg::ssw_tmr_s s;
	ssw_pkg::ssw_tmr_s next_s;

	always_comb begin
		next_s = s;
		if (tif.load) begin
			next_s.cnt = tif.loadVal;
		end else if (tif.run && (s.cnt != 32'h0)) begin
			next_s.cnt = s.cnt - 32'h1;
		end
	end

	// Expiry when the loaded count has run down to zero
	assign tif.expired = tif.run && (s.cnt == 32'h0);

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule

// ---- dv/ssw_top_properties.sv ----
/*
 Port checker of the supervisor, bound into ssw_top.
 Assumes ce held high and a single clock domain.
*/
module ssw_top_chk #(
	parameter int RST_DELAY_MS = 200
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        supplyAboveMin,
	input wire logic        supplyAboveLower,
	input wire logic        supplyAboveUpper,
	input wire logic        supplyDeepBelow,
	input wire logic        manualResetInN,
	input wire logic        watchdogKickIn,
	input wire logic        watchdogEnablePin,
	input wire logic        resetOutOe,
	input wire logic        watchdogFaultOe,
	input wire logic        irq,
	input wire logic        regRdStb,
	input wire logic [31:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RST_CYC = RST_DELAY_MS * 10000;
	// Below the shortest nominal timeout, 10000 cycles, that the bench runs with the watchdog on
	localparam int MIN_GAP = 9000;
	int   fltCnt, gapCnt, uvCnt, deepCnt, enLow;
	logic kickQ;

	// Run lengths of fault, kick gap, dips and disabled watchdog
	always_ff @(posedge clk) begin
		kickQ <= watchdogKickIn;
		fltCnt <= watchdogFaultOe ? fltCnt + 1 : 0;
		gapCnt <= (rst || resetOutOe || (kickQ && !watchdogKickIn)) ? 0 : gapCnt + 1;
		uvCnt <= supplyAboveLower ? 0 : uvCnt + 1;
		deepCnt <= (supplyAboveLower || !supplyDeepBelow) ? 0 : deepCnt + 1;
		enLow <= watchdogEnablePin ? 0 : enLow + 1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_float_in_reset: assert property (resetOutOe |-> !watchdogFaultOe)
		else $error("fault output driven during reset");
	chk_below_min: assert property (!supplyAboveMin [*4] |-> resetOutOe)
		else $error("no reset below minimum supply");
	chk_manual_reset: assert property (!manualResetInN [*4] |-> resetOutOe)
		else $error("no reset on manual request");
	chk_release_cause: assert property ($fell(resetOutOe) |-> supplyAboveMin && supplyAboveUpper && manualResetInN)
		else $error("reset released below rising threshold");
	chk_shallow_dip: assert property (uvCnt == 66 |-> resetOutOe)
		else $error("long shallow dip did not reset");
	chk_deep_dip: assert property (deepCnt == 16 |-> resetOutOe)
		else $error("deep dip did not reset quickly");
	chk_fault_enabled: assert property ($rose(watchdogFaultOe) |-> enLow < 3)
		else $error("fault with watchdog disabled");
	chk_fault_width: assert property ($fell(watchdogFaultOe) && !resetOutOe |-> fltCnt >= RST_CYC && fltCnt <= RST_CYC + 2)
		else $error("fault pulse width wrong");
	chk_fault_gap: assert property ($rose(watchdogFaultOe) |-> gapCnt >= MIN_GAP)
		else $error("fault before timeout");
	chk_read_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
		else $error("read data outside its cycle");

	cover property ($rose(watchdogFaultOe));
	cover property ($fell(resetOutOe));
	cover property ($rose(irq));
endmodule

bind ssw_top ssw_top_chk #(.RST_DELAY_MS(RST_DELAY_MS)) ssw_top_chk_i (
	.clk               (clk),
	.rst               (rst),
	.supplyAboveMin    (supplyAboveMin),
	.supplyAboveLower  (supplyAboveLower),
	.supplyAboveUpper  (supplyAboveUpper),
	.supplyDeepBelow   (supplyDeepBelow),
	.manualResetInN    (manualResetInN),
	.watchdogKickIn    (watchdogKickIn),
	.watchdogEnablePin (watchdogEnablePin),
	.resetOutOe        (resetOutOe),
	.watchdogFaultOe   (watchdogFaultOe),
	.irq               (irq),
	.regRdStb          (regRdStb),
	.regRdData         (regRdData)
);

// ---- dv/ssw_mcu_model.sv ----
/*
 Controller model: receives reset and kicks the watchdog.
 Assumes the bench sets the kick period and switches kicking on.
*/
module ssw_mcu_model (
	input wire logic        clk,
	input wire logic        resetOutOe,
	input wire logic        kickOn,
	input wire logic [15:0] period,
	output logic            kick
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;

	initial kick = 1'b1;
	// One-cycle low pulse each period, idle high while held in reset
	always @(posedge clk) begin
		if (resetOutOe || !kickOn) begin
			cnt <= 0;
			kick <= 1'b1;
		end else begin
			cnt <= (cnt >= period - 1) ? 0 : cnt + 1;
			kick <= !(cnt == period - 1);
		end
	end
endmodule

// ---- dv/ssw_top_tb.sv ----
/*
 Self-checking bench of ssw_top with a controller model.
 Assumes shortened factory and reset delays set at the instance.
*/
module ssw_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, ce, supplyAboveMin, supplyAboveLower, supplyAboveUpper, supplyDeepBelow;
	logic        manualResetInN, watchdogKickIn, watchdogEnablePin, timingPinOpen, timingPinPulled;
	logic        extendedScaling, resetOutN, resetOutOe, watchdogFaultOut, watchdogFaultOe, irq, kickOn;
	logic        regWrStb, regRdStb;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData;
	logic [15:0] period;
	int          fails, n_tests, n;
	// Pins {open, pulled, extended}: open, capacitor standard, capacitor extended, pulled
	logic [2:0]  cfg [4]    = '{3'h4, 3'h0, 3'h1, 3'h2};
	logic [31:0] expNom [4] = '{32'h4e20, 32'h1b80, 32'h992c8, 32'h2710};
	logic [31:0] expMin [4] = '{32'h4268, 32'h18e3, 32'h8a9f5, 32'h2134};
	logic [31:0] expMax [4] = '{32'h59d8, 32'h1e1c, 32'ha7b9b, 32'h2cec};

	ssw_top #(.FLOAT_TIMEOUT_MS(2), .PULL_TIMEOUT_MS(1), .RST_DELAY_MS(1)) ssw_top_i (.*);
	ssw_mcu_model ssw_mcu_model_i (.clk, .resetOutOe, .kickOn, .period, .kick(watchdogKickIn));

	always #50 clk = !clk;

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk);
		regWrStb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk);
		regRdStb <= 1'b0;
		@(negedge clk);
		chk(regRdData, exp, what);
		@(posedge clk);
	endtask

	// Bounded wait for reset or fault enable to reach a level; n gives cycles
	task automatic waitOe(input bit fault, input logic val, input int lim);
		n = 0;
		@(negedge clk);
		while ((fault ? watchdogFaultOe : resetOutOe) !== val) begin
			if (++n > lim) begin
				fails++;
				$display("MISMATCH %0t wait expired", $time);
				tally_and_finish();
			end
			@(negedge clk);
		end
		@(posedge clk);
	endtask

	// Caller evaluates the level at a falling edge, where outputs have settled
	task automatic sense(input logic v, input string what);
		chk({31'h0, v}, 32'h1, what);
		@(posedge clk);
	endtask

	initial begin
		{clk, ce, rst, supplyAboveLower, supplyAboveUpper, manualResetInN} = 6'h3f;
		{supplyAboveMin, supplyDeepBelow, watchdogEnablePin, kickOn, regWrStb, regRdStb} = 6'h0;
		{timingPinOpen, timingPinPulled, extendedScaling} = 3'h4;
		{regAddr, regWrData, period} = 56'h0;
		cyc(10);
		rst <= 1'b0;
		cyc(5);
		@(negedge clk);
		sense(resetOutOe && !watchdogFaultOe, "reset below minimum");
		rd(8'h00, 32'ha, "control default");
		rd(8'h08, 32'h0, "mask default");
		rd(8'h20, 32'h0, "unmapped read");
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1, "control written");
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			supplyAboveMin <= 1'b0;
			cyc(10);
			{timingPinOpen, timingPinPulled, extendedScaling} <= cfg[i];
			cyc(4);
			supplyAboveMin <= 1'b1;
			cyc(10);
			rd(8'h10, expNom[i], "nominal timeout");
			rd(8'h14, expMin[i], "least timeout");
			rd(8'h18, expMax[i], "most timeout");
		end
		timingPinOpen <= 1'b1;
		cyc(5);
		rd(8'h10, 32'h2710, "held configuration");
		timingPinOpen <= 1'b0;
		waitOe(0, 1'b0, 11000);
		rd(8'h04, 32'h4, "latch event");
		rd(8'h0c, 32'h188, "state word");
		$display("configuration done");
		cyc(12000);
		@(negedge clk);
		sense(!watchdogFaultOe, "disabled watchdog");
		ce <= 1'b0;
		rd(8'h10, 32'h0, "frozen read");
		ce <= 1'b1;
		watchdogEnablePin <= 1'b1;
		waitOe(1, 1'b1, 12000);
		@(negedge clk);
		sense(n >= 11500 && n <= 11510, "setup plus timeout");
		@(negedge clk);
		sense(!irq, "masked event");
		wr(8'h08, 32'h2);
		@(negedge clk);
		sense(irq, "unmasked event");
		rd(8'h04, 32'h2, "fault event");
		@(negedge clk);
		sense(!irq, "cleared event");
		waitOe(1, 1'b0, 10100);
		$display("timeout done");
		period <= 16'd4000;
		kickOn <= 1'b1;
		cyc(15000);
		@(negedge clk);
		sense(!watchdogFaultOe, "kicked watchdog");
		rd(8'h04, 32'h0, "no fault event");
		$display("kick done");
		supplyAboveLower <= 1'b0;
		cyc(5);
		supplyAboveLower <= 1'b1;
		cyc(20);
		@(negedge clk);
		sense(!resetOutOe, "short glitch");
		supplyAboveLower <= 1'b0;
		cyc(100);
		@(negedge clk);
		sense(resetOutOe && !watchdogFaultOe, "shallow dip");
		{supplyAboveLower, timingPinOpen} <= 2'h3;
		waitOe(0, 1'b0, 11000);
		rd(8'h04, 32'h5, "dip and latch events");
		rd(8'h10, 32'h4e20, "relatched configuration");
		{supplyAboveLower, supplyDeepBelow} <= 2'h1;
		cyc(20);
		@(negedge clk);
		sense(resetOutOe, "deep dip");
		{supplyAboveLower, supplyDeepBelow} <= 2'h2;
		waitOe(0, 1'b0, 11000);
		manualResetInN <= 1'b0;
		cyc(8);
		@(negedge clk);
		sense(resetOutOe, "manual reset");
		manualResetInN <= 1'b1;
		waitOe(0, 1'b0, 11000);
		$display("supply done");
		tally_and_finish();
	end
endmodule
